// [verilog/scrambler_pair.sv]
// Overview of operation
// [R1] Normal: line, data, taps 3, 20 odd parity
// [R2] Adverse state: same four bits even parity
// [R3] Count equal pairs eight apart, newest first
// [R4] Adverse when run is 31 modulo 32
// [R5] Scrambler history starts at arbitrary pattern
// [R6] Scrambler run count starts at arbitrary value
// [R7] Descrambler history and run start arbitrary
// [R8] Receiver trusts data after 20 bits, difference
// [R9] Each side keeps twenty-stage line history
// [R10] Test: scrambler detector can be bypassed
// [R11] Test: scrambler strapped to work as descrambler
// [R12] Outputs change on bit clock falling edge; rx_word_valid and rx_word_data change on any reference clock pop
// [R13] Descramble: received bit xor taps, detector
// [R14] Bypassed side passes bits unchanged, same timing
`timescale 1ns/1ps
module scrambler_pair
  import scrambler_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic bit_clk,
  input  wire logic tx_data,
  input  wire logic rx_line,
  input  wire logic asd_bypass,
  input  wire logic scr_bypass,
  input  wire logic scr_strap_descr,
  input  wire logic descr_bypass,
  input  wire logic rx_word_ready,
  output logic      tx_line,
  output logic      rx_data,
  output logic      rx_word_valid,
  output logic      rx_word_data,
  output logic      rx_settled,
  output logic      rx_overrun
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic              bclk_prev_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r     <= '0;
      sync2_r     <= '0;
      bclk_prev_r <= 1'b0;
    end else begin
      sync1_r     <= {descr_bypass, scr_strap_descr, scr_bypass, asd_bypass, rx_line, tx_data, bit_clk};
      sync2_r     <= sync1_r;
      bclk_prev_r <= sync2_r[SY_BCLK];
    end
  end

  logic step;
  logic tx_in, rx_in, asd_byp, scr_byp, scr_strap, dsc_byp;

  assign step      = bclk_prev_r && !sync2_r[SY_BCLK];  // [R12]
  assign tx_in     = sync2_r[SY_TXD];
  assign rx_in     = sync2_r[SY_RXL];
  assign asd_byp   = sync2_r[SY_ASD_BYP];
  assign scr_byp   = sync2_r[SY_SCR_BYP];
  assign scr_strap = sync2_r[SY_SCR_STRAP];
  assign dsc_byp   = sync2_r[SY_DSC_BYP];

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  // Xor with the inverted adverse flag gives odd parity normally, even when adverse
  function automatic logic parity_bit(input logic d, input logic [HIST_W-1:0] h, input logic adv);
    parity_bit = d ^ h[TAP_NEAR] ^ h[TAP_FAR] ^ !adv;  // [R1] [R2] [R13]
  endfunction : parity_bit

  // Newest pair is the incoming bit against the bit eight back; wraps mod 32
  function automatic logic [RUN_W-1:0] run_step(input logic [RUN_W-1:0] run, input logic [HIST_W-1:0] h,
                                                input logic b);
    run_step = (b == h[PAIR_TAP]) ? RUN_W'(run + RUN_ONE) : '0;  // [R3]
  endfunction : run_step

  // ----------------------------------------------------------------
  // Datapath state
  // ----------------------------------------------------------------
  logic [HIST_W-1:0]   scr_hist_r, scr_hist_nxt, dsc_hist_r, dsc_hist_nxt;
  logic [RUN_W-1:0]    scr_run_r, scr_run_nxt, dsc_run_r, dsc_run_nxt;
  logic                tx_line_r, tx_line_nxt, rx_data_r, rx_data_nxt;
  settle_e             settle_r, settle_nxt;
  logic [SETTLE_W-1:0] settle_cnt_r, settle_cnt_nxt;
  logic                push_r, push_nxt, push_data_r, push_data_nxt;
  logic                overrun_r, overrun_nxt;
  logic                settled_r, settled_nxt;
  logic                scr_adv, dsc_adv, scr_out, scr_line_bit, scr_hist_bit, dsc_out;
  logic                wr_ready;

  always_comb begin
    scr_adv      = !asd_byp && (scr_run_r == RUN_FLAG);  // [R4] [R10]
    dsc_adv      = (dsc_run_r == RUN_FLAG);              // [R4]
    scr_out      = parity_bit(tx_in, scr_hist_r, scr_adv);
    // Strapped: the input is a line bit, so it feeds the history
    scr_line_bit = scr_byp ? tx_in : scr_out;            // [R14]
    scr_hist_bit = scr_strap ? tx_in : scr_line_bit;     // [R11]
    dsc_out      = dsc_byp ? rx_in : parity_bit(rx_in, dsc_hist_r, dsc_adv);  // [R13] [R14]

    scr_hist_nxt   = scr_hist_r;
    scr_run_nxt    = scr_run_r;
    dsc_hist_nxt   = dsc_hist_r;
    dsc_run_nxt    = dsc_run_r;
    tx_line_nxt    = tx_line_r;
    rx_data_nxt    = rx_data_r;
    settle_nxt     = settle_r;
    settle_cnt_nxt = settle_cnt_r;
    push_nxt       = 1'b0;
    push_data_nxt  = push_data_r;
    overrun_nxt    = overrun_r;

    if (step) begin
      tx_line_nxt  = scr_line_bit;                          // [R12]
      rx_data_nxt  = dsc_out;                               // [R12]
      scr_run_nxt  = run_step(scr_run_r, scr_hist_r, scr_hist_bit);  // [R3]
      dsc_run_nxt  = run_step(dsc_run_r, dsc_hist_r, rx_in);         // [R3]
      scr_hist_nxt = {scr_hist_r[HIST_W-2:0], scr_hist_bit};         // [R9]
      dsc_hist_nxt = {dsc_hist_r[HIST_W-2:0], rx_in};                // [R9]

      // Output is only trusted after a full history and one differing pair
      case (settle_r)  // [R8]
        SETTLE_FILL: begin
          settle_cnt_nxt = SETTLE_W'(settle_cnt_r + SETTLE_ONE);
          if (settle_cnt_nxt == SETTLE_BITS) begin
            settle_nxt = SETTLE_DIFF;
          end
        end
        SETTLE_DIFF: begin
          if (rx_in != dsc_hist_r[PAIR_TAP]) begin
            settle_nxt = SETTLE_DONE;
          end
        end
        SETTLE_DONE: begin
          settle_nxt = SETTLE_DONE;
        end
        default: begin
          settle_nxt = SETTLE_FILL;
        end
      endcase

      if (settle_r == SETTLE_DONE) begin
        // The line cannot be stalled, so a full buffer drops the bit
        if (wr_ready) begin
          push_nxt      = 1'b1;
          push_data_nxt = dsc_out;
        end else begin
          overrun_nxt = 1'b1;
        end
      end
    end
    settled_nxt = (settle_nxt == SETTLE_DONE);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scr_hist_r   <= SCR_HIST_INIT;  // [R5]
      scr_run_r    <= SCR_RUN_INIT;   // [R6]
      dsc_hist_r   <= DSC_HIST_INIT;  // [R7]
      dsc_run_r    <= DSC_RUN_INIT;   // [R7]
      tx_line_r    <= 1'b0;
      rx_data_r    <= 1'b0;
      settle_r     <= SETTLE_FILL;
      settle_cnt_r <= '0;
      push_r       <= 1'b0;
      push_data_r  <= 1'b0;
      overrun_r    <= 1'b0;
      settled_r    <= 1'b0;
    end else begin
      scr_hist_r   <= scr_hist_nxt;
      scr_run_r    <= scr_run_nxt;
      dsc_hist_r   <= dsc_hist_nxt;
      dsc_run_r    <= dsc_run_nxt;
      tx_line_r    <= tx_line_nxt;
      rx_data_r    <= rx_data_nxt;
      settle_r     <= settle_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      push_r       <= push_nxt;
      push_data_r  <= push_data_nxt;
      overrun_r    <= overrun_nxt;
      settled_r    <= settled_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  stream_if #(.WIDTH(FIFO_WIDTH)) fifo_wr ();
  stream_if #(.WIDTH(FIFO_WIDTH)) fifo_rd ();

  assign fifo_wr.valid = push_r;
  assign fifo_wr.data  = push_data_r;
  assign wr_ready      = fifo_wr.ready;
  assign fifo_rd.ready = rx_word_ready;

  bit_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) i_bit_fifo (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .wr      (fifo_wr),
    .rd      (fifo_rd)
  );

  assign tx_line       = tx_line_r;
  assign rx_data       = rx_data_r;
  assign rx_word_valid = fifo_rd.valid;
  assign rx_word_data  = fifo_rd.data;
  assign rx_settled    = settled_r;
  assign rx_overrun    = overrun_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  property p_odd_parity;
    step && !scr_byp && !scr_adv |=>
      (tx_line_r ^ $past(tx_in) ^ $past(scr_hist_r[TAP_NEAR]) ^ $past(scr_hist_r[TAP_FAR])) == 1'b1;
  endproperty
  a_odd_parity: assert property (p_odd_parity) else $error("scrambler parity not odd");  // [R1]

  property p_even_parity;
    step && !scr_byp && scr_adv |=>
      (tx_line_r ^ $past(tx_in) ^ $past(scr_hist_r[TAP_NEAR]) ^ $past(scr_hist_r[TAP_FAR])) == 1'b0;
  endproperty
  a_even_parity: assert property (p_even_parity) else $error("scrambler parity not even");  // [R2]

  property p_run_count;
    step |=> scr_run_r == (($past(scr_hist_bit) == $past(scr_hist_r[PAIR_TAP]))
                           ? RUN_W'($past(scr_run_r) + RUN_ONE) : '0);
  endproperty
  a_run_count: assert property (p_run_count) else $error("run counter update wrong");  // [R3]

  property p_adverse_at_31;
    step && !asd_byp && (scr_run_r == RUN_FLAG - RUN_ONE) && (scr_hist_bit == scr_hist_r[PAIR_TAP])
      ##1 !asd_byp |-> scr_adv;
  endproperty
  a_adverse_at_31: assert property (p_adverse_at_31) else $error("adverse state missed");  // [R4]

  property p_history_shift;
    step |=> scr_hist_r[HIST_W-1:1] == $past(scr_hist_r[HIST_W-2:0])
             && dsc_hist_r == {$past(dsc_hist_r[HIST_W-2:0]), $past(rx_in)};
  endproperty
  a_history_shift: assert property (p_history_shift) else $error("history not shifted");  // [R9]

  property p_detector_bypass;
    asd_byp |-> !scr_adv;
  endproperty
  a_detector_bypass: assert property (p_detector_bypass) else $error("bypassed detector fired");  // [R10]

  property p_strap_history;
    step && scr_strap |=> scr_hist_r[0] == $past(tx_in);
  endproperty
  a_strap_history: assert property (p_strap_history) else $error("strap history wrong");  // [R11]

  property p_falling_edge_only;
    !$stable(tx_line_r) || !$stable(rx_data_r) |-> $past(step);
  endproperty
  a_falling_edge_only: assert property (p_falling_edge_only) else $error("output moved off edge");  // [R12]

  property p_descramble;
    step && !dsc_byp |=> rx_data_r == ($past(rx_in) ^ $past(dsc_hist_r[TAP_NEAR])
                                        ^ $past(dsc_hist_r[TAP_FAR]) ^ !$past(dsc_adv));
  endproperty
  a_descramble: assert property (p_descramble) else $error("descrambled bit wrong");  // [R13]

  property p_pass_through;
    step && scr_byp && dsc_byp |=> tx_line_r == $past(tx_in) && rx_data_r == $past(rx_in);
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("bypass altered data");  // [R14]

  property p_settle_gate;
    push_r |-> $past(settle_r) == SETTLE_DONE;
  endproperty
  a_settle_gate: assert property (p_settle_gate) else $error("unsettled bit buffered");  // [R8]

  property p_descr_pass;
    step && dsc_byp |=> rx_data_r == $past(rx_in);
  endproperty
  a_descr_pass: assert property (p_descr_pass) else $error("descrambler bypass altered data");  // [R14]

  property p_descr_adverse;
    step && (dsc_run_r == RUN_FLAG - RUN_ONE) && (rx_in == dsc_hist_r[PAIR_TAP]) |=> dsc_adv;
  endproperty
  a_descr_adverse: assert property (p_descr_adverse) else $error("receive adverse state missed");  // [R4]

  property p_settle_needs_diff;
    step && (settle_r == SETTLE_DIFF) && (rx_in == dsc_hist_r[PAIR_TAP]) |=> settle_r == SETTLE_DIFF;
  endproperty
  a_settle_needs_diff: assert property (p_settle_needs_diff) else $error("settled with no difference");  // [R8]

  c_adverse:   cover property (step && scr_adv);
  c_settled:   cover property (!rx_settled ##1 rx_settled);
  c_overrun:   cover property (!rx_overrun ##1 rx_overrun);
  c_bypass:    cover property (step && scr_byp && dsc_byp);

endmodule : scrambler_pair

// [verilog/scrambler_pkg.sv]
package scrambler_pkg;

  // ----------------------------------------------------------------
  // Line history and parity taps
  // ----------------------------------------------------------------
  localparam int HIST_W   = 20;
  localparam int TAP_NEAR = 2;   // third earlier bit
  localparam int TAP_FAR  = 19;  // twentieth earlier bit
  localparam int PAIR_TAP = 7;   // partner of the newest bit, eight positions back

  // ----------------------------------------------------------------
  // Adverse state run counter
  // ----------------------------------------------------------------
  localparam int             RUN_W    = 5;
  localparam logic [RUN_W-1:0] RUN_FLAG = 5'h1f;
  localparam logic [RUN_W-1:0] RUN_ONE  = 5'h01;

  // ----------------------------------------------------------------
  // Start-up values, any pattern is legal
  // ----------------------------------------------------------------
  localparam logic [HIST_W-1:0] SCR_HIST_INIT = 20'h9c3a5;
  localparam logic [HIST_W-1:0] DSC_HIST_INIT = 20'h36e1d;
  localparam logic [RUN_W-1:0]  SCR_RUN_INIT  = 5'h00;
  localparam logic [RUN_W-1:0]  DSC_RUN_INIT  = 5'h00;

  // ----------------------------------------------------------------
  // Receive settling and buffering
  // ----------------------------------------------------------------
  localparam int              SETTLE_W    = 5;
  localparam logic [SETTLE_W-1:0] SETTLE_BITS = 5'h14;
  localparam logic [SETTLE_W-1:0] SETTLE_ONE  = 5'h01;
  localparam int              FIFO_WIDTH  = 1;
  localparam int              FIFO_DEPTH  = 8;

  // ----------------------------------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SYNC_W        = 7;
  localparam int SY_BCLK       = 0;
  localparam int SY_TXD        = 1;
  localparam int SY_RXL        = 2;
  localparam int SY_ASD_BYP    = 3;
  localparam int SY_SCR_BYP    = 4;
  localparam int SY_SCR_STRAP  = 5;
  localparam int SY_DSC_BYP    = 6;

  typedef enum logic [2:0] {
    SETTLE_FILL = 3'b001,
    SETTLE_DIFF = 3'b010,
    SETTLE_DONE = 3'b100
  } settle_e;

endpackage : scrambler_pkg

// [verilog/stream_if.sv]
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 1);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// [verilog/bit_fifo.sv]
`timescale 1ns/1ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  stream_if.snk    wr,
  stream_if.src    rd
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0]    cnt_r, cnt_nxt;
  logic             vld_r, vld_nxt, rdy_r, rdy_nxt;
  logic [WIDTH-1:0] dat_r, dat_nxt;
  logic             push, pop;

  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
    ptr_step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_step

  // ----------------------------------------------------------------
  // Next state; head word is read from the next pointer so the
  // output register always holds the current head
  // ----------------------------------------------------------------
  always_comb begin
    push    = wr.valid && rdy_r;
    pop     = rd.ready && vld_r;
    wp_nxt  = push ? ptr_step(wp_r) : wp_r;
    rp_nxt  = pop ? ptr_step(rp_r) : rp_r;
    cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
    vld_nxt = (cnt_nxt != '0);
    rdy_nxt = (cnt_nxt != CW'(DEPTH));
    // Bypass a word written into the slot that becomes the head
    dat_nxt = (push && (wp_r == rp_nxt)) ? wr.data : mem[rp_nxt];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      vld_r <= 1'b0;
      rdy_r <= 1'b1;
      dat_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      vld_r <= vld_nxt;
      rdy_r <= rdy_nxt;
      dat_r <= dat_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end

  assign wr.ready = rdy_r;
  assign rd.valid = vld_r;
  assign rd.data  = dat_r;

endmodule : bit_fifo

// [tb/line_partner.sv]
`timescale 1ns/1ps
module line_partner #(
  parameter int HALF = 8
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic tx_line,
  output logic      bit_clk,
  output logic      rx_line
);
  int cnt;

  // ----------------------------------------------------------------
  // Modem bit clock, free running while the link is up
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt     <= 0;
      bit_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt     <= 0;
      bit_clk <= ~bit_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Line loops straight back, so the receiver sees one bit of delay
  assign rx_line = tx_line;
endmodule : line_partner

// [tb/adverse_state_scrambler_pair_tb.sv]
`timescale 1ns/1ps
module adverse_state_scrambler_pair_tb;
  import scrambler_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              tx_data = 1'b0;
  logic              asd_bypass = 1'b0;
  logic              scr_bypass = 1'b0;
  logic              scr_strap_descr = 1'b0;
  logic              descr_bypass = 1'b0;
  logic              rx_word_ready = 1'b1;
  logic              bit_clk, rx_line, tx_line, rx_data;
  logic              rx_word_valid, rx_word_data, rx_settled, rx_overrun;
  logic [HIST_W-1:0] hs = SCR_HIST_INIT;
  logic [HIST_W-1:0] hd = DSC_HIST_INIT;
  logic [RUN_W-1:0]  rs = SCR_RUN_INIT;
  logic [RUN_W-1:0]  rd = DSC_RUN_INIT;
  logic              tx_e = 1'b0;
  logic              rx_e;
  logic              q [0:7];
  logic [7:0]        bad;
  int                n_errors = 0;
  int                cmp_count = 0;
  int                nbit = 0;

  always #12.5 ref_clk = ~ref_clk;

  scrambler_pair i_scrambler_pair (
    .ref_clk(ref_clk), .rst_b(rst_b), .bit_clk(bit_clk), .tx_data(tx_data),
    .rx_line(rx_line), .asd_bypass(asd_bypass), .scr_bypass(scr_bypass),
    .scr_strap_descr(scr_strap_descr), .descr_bypass(descr_bypass),
    .rx_word_ready(rx_word_ready), .tx_line(tx_line), .rx_data(rx_data),
    .rx_word_valid(rx_word_valid), .rx_word_data(rx_word_data),
    .rx_settled(rx_settled), .rx_overrun(rx_overrun)
  );

  line_partner i_line_partner (
    .ref_clk(ref_clk), .rst_b(rst_b), .tx_line(tx_line),
    .bit_clk(bit_clk), .rx_line(rx_line)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // One bit time: drive, step both reference sides, compare
  // ----------------------------------------------------------------
  task automatic run_bit(input logic d);
    logic as, ad, s, r;
    @(posedge bit_clk);
    chk(tx_line, tx_e);
    @(posedge ref_clk);
    tx_data <= d;
    @(negedge bit_clk);
    r    = tx_e;
    as   = (rs == RUN_FLAG) && !asd_bypass;
    s    = d ^ hs[TAP_NEAR] ^ hs[TAP_FAR] ^ !as;
    tx_e = scr_bypass ? d : s;
    s    = scr_strap_descr ? d : tx_e;
    rs   = (s == hs[PAIR_TAP]) ? rs + RUN_ONE : '0;
    hs   = {hs[HIST_W-2:0], s};
    ad   = (rd == RUN_FLAG);
    rx_e = descr_bypass ? r : r ^ hd[TAP_NEAR] ^ hd[TAP_FAR] ^ !ad;
    rd   = (r == hd[PAIR_TAP]) ? rd + RUN_ONE : '0;
    hd   = {hd[HIST_W-2:0], r};
    nbit++;
    // Outputs land a few cycles after the step; sample well clear of it
    repeat (6) @(negedge ref_clk);
    chk(tx_line, tx_e);
    chk(rx_data, rx_e);
    if (nbit <= 20) chk(rx_settled, 1'b0);
  endtask : run_bit

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_normal();
    for (int i = 0; i < 64; i++) run_bit(i[0] ^ i[3] ^ (i > 40));
    chk(rx_settled, 1'b1);
  endtask : t_normal

  task automatic t_asd_bypass();
    logic pd;
    // A bypassed scrambler lays an in-phase 1:1 history, so without a
    // detector the line keeps echoing the 1:1 data afterwards
    @(posedge ref_clk);
    asd_bypass <= 1'b1;
    scr_bypass <= 1'b1;
    for (int i = 0; i < 24; i++) run_bit(i[0]);
    @(posedge ref_clk);
    scr_bypass <= 1'b0;
    bad = '0;
    pd  = 1'b1;
    for (int i = 0; i < 192; i++) begin
      run_bit(i[0]);
      if (i >= 64 && rx_data !== pd) bad++;
      pd = i[0];
    end
    chk(bad, 8'h04);
  endtask : t_asd_bypass

  task automatic t_strap();
    @(posedge ref_clk);
    asd_bypass      <= 1'b0;
    scr_strap_descr <= 1'b1;
    descr_bypass    <= 1'b1;
    bad = '0;
    for (int i = 0; i < 192; i++) begin
      // A 1:1 line into the strapped scrambler comes back 1:1, its own
      // detector inverting one bit in every 32
      run_bit(i[0]);
      if (i >= 64 && tx_line !== i[0]) bad++;
    end
    chk(bad, 8'h04);
  endtask : t_strap

  task automatic t_bypass();
    @(posedge ref_clk);
    scr_strap_descr <= 1'b0;
    scr_bypass      <= 1'b1;
    for (int i = 0; i < 24; i++) run_bit(i[1] ^ i[2]);
  endtask : t_bypass

  task automatic t_fifo();
    @(posedge ref_clk);
    scr_bypass    <= 1'b0;
    descr_bypass  <= 1'b0;
    rx_word_ready <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      run_bit(i[1]);
      if (i < 8) q[i] = rx_e;
      if (i == 7) chk(rx_overrun, 1'b0);
    end
    chk(rx_overrun, 1'b1);
    // Drain between two steps so no push lands during the pops
    @(posedge ref_clk);
    rx_word_ready <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      chk({rx_word_valid, rx_word_data}, {1'b1, q[i]});
    end
    @(negedge ref_clk);
    chk(rx_word_valid, 1'b0);
  endtask : t_fifo

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_normal();
    t_asd_bypass();
    t_strap();
    t_bypass();
    t_fifo();
    test_done();
  end

  initial begin
    // About 505 bit times of 16 cycles, some 200 us, with ample margin
    #500us;
    n_errors++;
    test_done();
  end
endmodule : adverse_state_scrambler_pair_tb
